// *** inc/igdpc_pkg.sv ***
// Purpose: Shared constants for the ignition driver protection control.
// Assumes: 10 MHz system clock; fault sources arrive as synchronous levels.
// Notes:   Filter counts are kept in internal clock periods.
package igdpc_pkg;

  // Clock rate and filter reference
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned FILT_CLK_HZ   = 2_000_000;
  localparam int unsigned CMD_FILT_PER  = 32;
  localparam int unsigned DIS_FILT_PER  = 32;
  localparam int unsigned FLAG_FILT_PER = 16;
  // Filter lengths in system clock cycles
  localparam int unsigned CMD_FILT_CYC  =
    (CMD_FILT_PER * (CLK_HZ / FILT_CLK_HZ) < 1) ? 1 :
    CMD_FILT_PER * (CLK_HZ / FILT_CLK_HZ);
  localparam int unsigned DIS_FILT_CYC  =
    (DIS_FILT_PER * (CLK_HZ / FILT_CLK_HZ) < 1) ? 1 :
    DIS_FILT_PER * (CLK_HZ / FILT_CLK_HZ);
  localparam int unsigned FLAG_FILT_CYC =
    (FLAG_FILT_PER * (CLK_HZ / FILT_CLK_HZ) < 1) ? 1 :
    FLAG_FILT_PER * (CLK_HZ / FILT_CLK_HZ);

  // Supply overvoltage qualification time
  localparam int unsigned SUPPLY_QUAL_US  = 220;
  localparam int unsigned SUPPLY_QUAL_CYC =
    (SUPPLY_QUAL_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
    SUPPLY_QUAL_US * (CLK_HZ / 1_000_000);

  // Reset values of the filtered pins
  localparam logic CMD_RESET_LEVEL = 1'b0;
  localparam logic DIS_RESET_LEVEL = 1'b1;

  typedef enum logic [1:0] {
    IGDPC_OFF,
    IGDPC_ON,
    IGDPC_SHUTDOWN,
    IGDPC_LOCKED
  } igdpc_state_t;

endpackage : igdpc_pkg

// *** src/igdpc_control.sv ***
// Purpose: Switching and protection control of an ignition coil driver.
// Assumes: Fault inputs and coil current compare are synchronous levels.
// Notes:   Analog clamp and discharge are driven by the outputs here.
// What this block does
// - Enabled, command rise turns stage on, command fall turns it off.
// - Any fault starts soft shutdown.
// - Disable rising while command high is a disable-while-on fault.
// - Rising disable is latched and shutdown runs to full discharge.
// - After disable, restart needs disable low then fresh command rise.
// - Undriven disable pin reads as disabled.
// - Thermal shutdown discharges only while command high, until zero.
// - Command transition during shutdown releases the low clamp at once.
// - Thermal trip keeps stage off until hysteresis recovery.
// - Flag falls after filter on command high, rises at threshold.
// - Flag output is open drain, pulls low or releases.
// - Undriven command pin reads as low.
// - Command overvoltage discharges only while it is detected.
// - After command overvoltage clears, high command turns on again.
// - Supply overvoltage held past qualification forces full discharge.
// - After supply overvoltage, off until recovered and fresh rise.
// - Flag filtered 16 periods, command and disable 32 periods.
`timescale 1ns/1ps
module igdpc_control
  import igdpc_pkg::*;
#(
  parameter int unsigned CMD_LEN    = CMD_FILT_CYC,
  parameter int unsigned DIS_LEN    = DIS_FILT_CYC,
  parameter int unsigned FLAG_LEN   = FLAG_FILT_CYC,
  parameter int unsigned SUPPLY_LEN = SUPPLY_QUAL_CYC
) (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic commandPin,
  input  wire logic commandPinDriven,
  input  wire logic disablePin,
  input  wire logic disablePinDriven,
  input  wire logic thermalTrip,
  input  wire logic commandOvervoltage,
  input  wire logic bondLoss,
  input  wire logic supplyTripLevel,
  input  wire logic coilCurrentZero,
  input  wire logic coilAtThreshold,
  output logic      stageOn,
  output logic      softShutdown,
  output logic      lowVoltageClamp,
  output logic      flagIn,
  output logic      flagOut,
  output logic      flagOe
);

  igdpc_state_t state_reg;
  igdpc_state_t state_next;

  logic        cmdRaw;
  logic        disRaw;
  logic        cmdLvl;
  logic        disLvl;
  logic        cmdPrev_reg;
  logic        disPrev_reg;
  logic        cmdRise;
  logic        cmdFall;
  logic        disRise;
  logic        disLatch_reg;
  logic        thermLatch_reg;
  logic        supplyLatch_reg;
  logic        supplyHigh;
  logic        ssdThermal_reg;
  logic        clampRelease_reg;
  logic        flagLow_reg;
  logic [15:0] supplyCnt_reg;
  logic [15:0] flagCnt_reg;
  logic        shutdownCause;
  logic        holdCause;
  logic        dischargeRun;
  logic        ssdCmdOv_reg;
  logic        flagArm_reg;

  // Floating pins resolve to safe levels
  assign cmdRaw = commandPinDriven ? commandPin : 1'b0;
  assign disRaw = disablePinDriven ? disablePin : 1'b1;

  igdpc_filter #(
    .LEN       (CMD_LEN),
    .RESET_LVL (CMD_RESET_LEVEL)
  ) u_cmd_filter (
    .clock    (clock),
    .reset_n  (reset_n),
    .pinIn    (cmdRaw),
    .levelOut (cmdLvl)
  );

  igdpc_filter #(
    .LEN       (DIS_LEN),
    .RESET_LVL (DIS_RESET_LEVEL)
  ) u_dis_filter (
    .clock    (clock),
    .reset_n  (reset_n),
    .pinIn    (disRaw),
    .levelOut (disLvl)
  );

  // Edge detection on filtered levels
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cmdPrev_reg <= CMD_RESET_LEVEL;
      disPrev_reg <= DIS_RESET_LEVEL;
    end else begin
      cmdPrev_reg <= cmdLvl;
      disPrev_reg <= disLvl;
    end
  end

  assign cmdRise = cmdLvl & ~cmdPrev_reg;
  assign cmdFall = ~cmdLvl & cmdPrev_reg;
  assign disRise = disLvl & ~disPrev_reg;

  // Supply overvoltage qualification
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      supplyCnt_reg <= '0;
    end else if (!supplyTripLevel) begin
      supplyCnt_reg <= '0;
    end else if (supplyCnt_reg != 16'(SUPPLY_LEN)) begin
      supplyCnt_reg <= supplyCnt_reg + 16'h0001;
    end
  end

  assign supplyHigh = (supplyCnt_reg == 16'(SUPPLY_LEN));

  // Disable event latch, cleared once pin low and fresh rise seen
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      disLatch_reg <= 1'b1;
    end else if (disRise || (disLvl && state_reg == IGDPC_ON)) begin
      disLatch_reg <= 1'b1;
    end else if (!disLvl && cmdRise) begin
      disLatch_reg <= 1'b0;
    end
  end

  // Thermal latch with hysteresis given by the trip input level
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      thermLatch_reg <= 1'b0;
    end else begin
      thermLatch_reg <= thermalTrip;
    end
  end

  // Supply overvoltage latch, needs recovery and fresh command rise
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      supplyLatch_reg <= 1'b0;
    end else if (supplyHigh) begin
      supplyLatch_reg <= 1'b1;
    end else if (!supplyTripLevel && cmdRise) begin
      supplyLatch_reg <= 1'b0;
    end
  end

  // Any fault that ends an on phase by soft shutdown
  assign shutdownCause = thermalTrip | commandOvervoltage | bondLoss |
                         supplyHigh | (disLvl & cmdLvl);
  // Faults that block turn-on; disable and supply latches are cleared
  // by the very command rise they wait for, so that rise may turn on
  assign holdCause = disLvl | thermLatch_reg | commandOvervoltage | bondLoss |
                     (supplyLatch_reg & supplyTripLevel) | supplyHigh;

  // Shutdown continuation per cause
  always_comb begin
    if (ssdThermal_reg) begin
      dischargeRun = cmdLvl;
    end else if (ssdCmdOv_reg) begin
      dischargeRun = commandOvervoltage;
    end else begin
      dischargeRun = 1'b1;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      IGDPC_OFF: begin
        if (cmdRise && !holdCause && !cmdFall) begin
          state_next = IGDPC_ON;
        end else if (cmdLvl && !holdCause && !disLatch_reg &&
                     !supplyLatch_reg && !thermLatch_reg &&
                     commandOvervoltage == 1'b0 &&
                     cmdPrev_reg && state_reg == IGDPC_LOCKED) begin
          state_next = IGDPC_ON;
        end
      end
      IGDPC_ON: begin
        if (shutdownCause) begin
          state_next = IGDPC_SHUTDOWN;
        end else if (cmdFall) begin
          state_next = IGDPC_OFF;
        end
      end
      IGDPC_SHUTDOWN: begin
        if (coilCurrentZero || clampRelease_reg) begin
          state_next = IGDPC_LOCKED;
        end else if (!commandOvervoltage && !ssdThermal_reg &&
                     !disLatch_reg && !supplyLatch_reg && !bondLoss &&
                     !thermalTrip && cmdLvl) begin
          state_next = IGDPC_ON;
        end else if (!dischargeRun) begin
          state_next = IGDPC_LOCKED;
        end
      end
      IGDPC_LOCKED: begin
        if (!holdCause && cmdRise) begin
          state_next = IGDPC_ON;
        end else if (!holdCause && cmdLvl && !disLatch_reg &&
                     !supplyLatch_reg) begin
          state_next = IGDPC_ON;
        end else if (!cmdLvl) begin
          state_next = IGDPC_OFF;
        end
      end
      default: state_next = IGDPC_OFF;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= IGDPC_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // Remember thermal as the shutdown cause
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ssdThermal_reg <= 1'b0;
    end else if (state_reg == IGDPC_ON && state_next == IGDPC_SHUTDOWN) begin
      ssdThermal_reg <= thermalTrip;
    end else if (state_reg != IGDPC_SHUTDOWN) begin
      ssdThermal_reg <= 1'b0;
    end
  end

  // Remember command overvoltage as the only shutdown cause
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ssdCmdOv_reg <= 1'b0;
    end else if (state_reg == IGDPC_ON && state_next == IGDPC_SHUTDOWN) begin
      ssdCmdOv_reg <= commandOvervoltage && !thermalTrip && !bondLoss &&
                      !supplyHigh && !(disLvl && cmdLvl);
    end else if (state_reg != IGDPC_SHUTDOWN) begin
      ssdCmdOv_reg <= 1'b0;
    end
  end

  // Command transition during shutdown releases the clamp
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      clampRelease_reg <= 1'b0;
    end else if (state_reg == IGDPC_SHUTDOWN && (cmdRise || cmdFall)) begin
      clampRelease_reg <= 1'b1;
    end else if (state_reg != IGDPC_SHUTDOWN) begin
      clampRelease_reg <= 1'b0;
    end
  end

  // Current flag: low after filter once command high, high at threshold
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flagCnt_reg <= '0;
      flagLow_reg <= 1'b0;
    end else if (coilAtThreshold || !cmdLvl || !(flagArm_reg || cmdRise)) begin
      flagCnt_reg <= '0;
      flagLow_reg <= 1'b0;
    end else if (flagCnt_reg == 16'(FLAG_LEN - 1)) begin
      flagLow_reg <= 1'b1;
    end else if (!flagLow_reg) begin
      flagCnt_reg <= flagCnt_reg + 16'h0001;
    end
  end

  // Flag cycle armed by a command rise, ended at threshold or command low
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flagArm_reg <= 1'b0;
    end else if (coilAtThreshold || !cmdLvl) begin
      flagArm_reg <= 1'b0;
    end else if (cmdRise) begin
      flagArm_reg <= 1'b1;
    end
  end

  // Open drain flag: drive low only
  assign flagOut = 1'b0;
  assign flagOe  = flagLow_reg;

  // Power stage and clamp outputs
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stageOn         <= 1'b0;
      softShutdown    <= 1'b0;
      lowVoltageClamp <= 1'b0;
    end else begin
      stageOn         <= (state_next == IGDPC_ON);
      softShutdown    <= (state_next == IGDPC_SHUTDOWN);
      lowVoltageClamp <= (state_next == IGDPC_SHUTDOWN) &&
                         !(cmdRise || cmdFall) &&
                         !clampRelease_reg;
    end
  end

  assign flagIn = flagLow_reg;

endmodule : igdpc_control

// *** src/igdpc_filter.sv ***
// Purpose: Synchroniser and stability filter for one input pin.
// Assumes: Pin level may change at any time.
// Notes:   Output changes only after the input held steady for LEN cycles.
`timescale 1ns/1ps
module igdpc_filter #(
  parameter int unsigned LEN        = 64,
  parameter logic        RESET_LVL  = 1'b0
) (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic pinIn,
  output logic      levelOut
);

  localparam int unsigned CW = $clog2(LEN + 1);

  logic          sync1_reg;
  logic          sync2_reg;
  logic [CW-1:0] count_reg;

  // Two-stage synchroniser
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= RESET_LVL;
      sync2_reg <= RESET_LVL;
    end else begin
      sync1_reg <= pinIn;
      sync2_reg <= sync1_reg;
    end
  end

  // Stability counter
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= '0;
      levelOut  <= RESET_LVL;
    end else if (sync2_reg == levelOut) begin
      count_reg <= '0;
    end else if (count_reg == CW'(LEN - 1)) begin
      count_reg <= '0;
      levelOut  <= sync2_reg;
    end else begin
      count_reg <= count_reg + CW'(1);
    end
  end

endmodule : igdpc_filter

// *** testbench/igdpc_control_chk.sv ***
// Purpose: Port assertions for the protection control.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Supply overvoltage time counted in helper logic.
`timescale 1ns/1ps
module igdpc_control_chk
  import igdpc_pkg::*;
#(
  parameter int unsigned CMD_LEN    = CMD_FILT_CYC,
  parameter int unsigned DIS_LEN    = DIS_FILT_CYC,
  parameter int unsigned FLAG_LEN   = FLAG_FILT_CYC,
  parameter int unsigned SUPPLY_LEN = SUPPLY_QUAL_CYC
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic commandPin,
  input wire logic commandPinDriven,
  input wire logic disablePin,
  input wire logic disablePinDriven,
  input wire logic thermalTrip,
  input wire logic commandOvervoltage,
  input wire logic bondLoss,
  input wire logic supplyTripLevel,
  input wire logic coilCurrentZero,
  input wire logic coilAtThreshold,
  input wire logic stageOn,
  input wire logic softShutdown,
  input wire logic lowVoltageClamp,
  input wire logic flagIn,
  input wire logic flagOut,
  input wire logic flagOe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  int unsigned supCnt;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) supCnt <= 0;
    else supCnt <= supplyTripLevel ? supCnt + 1 : 0;
  end
  a_flag_open_drain: assert property (flagOut == 1'b0)
    else $error("flag data not low");
  a_ssd_stage_off: assert property (softShutdown |-> !stageOn)
    else $error("stage on during shutdown");
  a_thermal_to_ssd: assert property (stageOn && thermalTrip |=>
    softShutdown && lowVoltageClamp && !stageOn)
    else $error("thermal trip ignored");
  a_bond_to_ssd: assert property (
    stageOn && bondLoss |=> softShutdown)
    else $error("bond loss ignored");
  a_supply_qual: assert property (
    supCnt > SUPPLY_LEN + 2 |-> !stageOn)
    else $error("stage on past supply qualification");
  a_flag_release: assert property (
    flagOe && coilAtThreshold |=> !flagOe)
    else $error("flag held at threshold");
  a_ssd_from_on: assert property (
    $rose(softShutdown) |-> $past(stageOn))
    else $error("shutdown without stage on");
  a_clamp_at_ssd: assert property (
    $rose(softShutdown) |-> lowVoltageClamp)
    else $error("clamp missing at shutdown");
  a_dis_blocks_on: assert property (
    (disablePin || !disablePinDriven) [*8] |-> !$rose(stageOn))
    else $error("stage on while disabled");
endmodule : igdpc_control_chk
bind igdpc_control igdpc_control_chk #(.CMD_LEN(CMD_LEN), .DIS_LEN(DIS_LEN),
  .FLAG_LEN(FLAG_LEN), .SUPPLY_LEN(SUPPLY_LEN)) u_chk (.clock(clock),
  .reset_n(reset_n), .commandPin(commandPin),
  .commandPinDriven(commandPinDriven), .disablePin(disablePin),
  .disablePinDriven(disablePinDriven), .thermalTrip(thermalTrip),
  .commandOvervoltage(commandOvervoltage), .bondLoss(bondLoss),
  .supplyTripLevel(supplyTripLevel), .coilCurrentZero(coilCurrentZero),
  .coilAtThreshold(coilAtThreshold), .stageOn(stageOn),
  .softShutdown(softShutdown), .lowVoltageClamp(lowVoltageClamp),
  .flagIn(flagIn), .flagOut(flagOut), .flagOe(flagOe));

// *** testbench/igdpc_ecu_model.sv ***
// Purpose: Engine control unit model on command and disable pins.
// Assumes: Requests change just after a rising edge.
// Notes:   A floating pin shows the inverse of its last driven level.
`timescale 1ns/1ps
module igdpc_ecu_model (
  input  wire logic clock,
  input  wire logic cmdReq,
  input  wire logic disReq,
  input  wire logic cmdFloat,
  input  wire logic disFloat,
  output logic      commandPin,
  output logic      commandPinDriven,
  output logic      disablePin,
  output logic      disablePinDriven
);
  logic cmdLast = 1'b0;
  logic disLast = 1'b0;
  always @(posedge clock) begin
    if (!cmdFloat) cmdLast <= cmdReq;
    if (!disFloat) disLast <= disReq;
  end
  // Driven pins follow the requests; a floating pin shows the inverse of its last driven level
  assign commandPin       = cmdFloat ? ~cmdLast : cmdReq;
  assign commandPinDriven = ~cmdFloat;
  assign disablePin       = disFloat ? ~disLast : disReq;
  assign disablePinDriven = ~disFloat;
endmodule : igdpc_ecu_model

// *** testbench/tb.sv ***
// Purpose: Self-checking bench for the protection control.
// Assumes: Shortened filter and qualification counts.
// Notes:   Coil and fault levels driven by the bench.
`timescale 1ns/1ps
module tb;
  import igdpc_pkg::*;
  localparam int CL = 4;
  localparam int SL = 20;
  localparam int LAT = CL + 3;
  logic clock = 1'b0, reset_n = 1'b0, cmdReq = 1'b0, disReq = 1'b0;
  logic cmdFloat = 1'b0, disFloat = 1'b0, therm = 1'b0, cmdOv = 1'b0;
  logic bond = 1'b0, supply = 1'b0, coilZero = 1'b0, coilThr = 1'b0;
  logic cmdPin, cmdDrv, disPin, disDrv;
  logic stageOn, soft_shutdown, low_voltage_clamp, flagIn, flagOut, flagOe;
  int errors = 0, n_tests = 0;
  always #50 clock = ~clock;
  igdpc_ecu_model ECU (.clock(clock), .cmdReq(cmdReq), .disReq(disReq),
    .cmdFloat(cmdFloat), .disFloat(disFloat), .commandPin(cmdPin),
    .commandPinDriven(cmdDrv), .disablePin(disPin),
    .disablePinDriven(disDrv));
  igdpc_control #(.CMD_LEN(CL), .DIS_LEN(CL), .FLAG_LEN(CL),
    .SUPPLY_LEN(SL)) DUT (.clock(clock), .reset_n(reset_n),
    .commandPin(cmdPin), .commandPinDriven(cmdDrv), .disablePin(disPin),
    .disablePinDriven(disDrv), .thermalTrip(therm),
    .commandOvervoltage(cmdOv), .bondLoss(bond),
    .supplyTripLevel(supply), .coilCurrentZero(coilZero),
    .coilAtThreshold(coilThr), .stageOn(stageOn), .softShutdown(soft_shutdown),
    .lowVoltageClamp(low_voltage_clamp), .flagIn(flagIn), .flagOut(flagOut),
    .flagOe(flagOe));
  task automatic final_report();
    if (errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  function automatic logic pick(input int w);
    case (w)
      0: return stageOn;
      1: return soft_shutdown;
      2: return low_voltage_clamp;
      default: return flagOe;
    endcase
  endfunction : pick
  task automatic waitV(input int w, input logic v, input int lim);
    repeat (lim) if (pick(w) !== v) @(posedge clock);
    chk(pick(w), v);
  endtask : waitV
  task automatic turnOn();
    cyc(LAT + 2);
    cmdReq <= 1'b1;
    cyc(LAT - 1);
    chk(stageOn, 1'b0);
    cyc(2);
    chk(stageOn, 1'b1);
  endtask : turnOn
  task automatic turnOff();
    cmdReq <= 1'b0;
    cyc(LAT + 2);
    chk(stageOn, 1'b0);
  endtask : turnOff
  task automatic discharge();
    coilZero <= 1'b1;
    waitV(1, 1'b0, 4);
    coilZero <= 1'b0;
    cyc(4);
  endtask : discharge
  task automatic t_switch();
    chk(soft_shutdown | flagOe | flagOut, 1'b0);
    turnOn();
    waitV(3, 1'b1, CL + 4);
    coilThr <= 1'b1;
    cyc(2);
    chk(flagOe, 1'b0);
    coilThr <= 1'b0;
    cyc(CL + 2);
    chk(flagOe, 1'b0);
    turnOff();
    cmdReq <= 1'b1;
    cyc(CL - 1);
    cmdReq <= 1'b0;
    cyc(LAT + 3);
    chk(stageOn, 1'b0);
  endtask : t_switch
  task automatic t_thermal();
    turnOn();
    therm <= 1'b1;
    cyc(2);
    chk(soft_shutdown & low_voltage_clamp & ~stageOn, 1'b1);
    cmdReq <= 1'b0;
    waitV(2, 1'b0, LAT + 2);
    cyc(4);
    cmdReq <= 1'b1;
    cyc(LAT + 3);
    chk(stageOn, 1'b0);
    therm <= 1'b0;
    turnOff();
  endtask : t_thermal
  task automatic t_disable();
    turnOn();
    disReq <= 1'b1;
    waitV(1, 1'b1, LAT + 3);
    disReq <= 1'b0;
    cyc(LAT + 2);
    chk(soft_shutdown, 1'b1);
    discharge();
    chk(stageOn, 1'b0);
    turnOff();
    turnOn();
    turnOff();
  endtask : t_disable
  task automatic t_faults();
    turnOn();
    cmdOv <= 1'b1;
    waitV(1, 1'b1, 3);
    cmdOv <= 1'b0;
    waitV(0, 1'b1, 8);
    bond <= 1'b1;
    waitV(1, 1'b1, 3);
    bond <= 1'b0;
    discharge();
    turnOff();
    turnOn();
    supply <= 1'b1;
    cyc(SL - 2);
    chk(stageOn, 1'b1);
    waitV(1, 1'b1, 8);
    discharge();
    supply <= 1'b0;
    cyc(LAT);
    chk(stageOn, 1'b0);
    turnOff();
  endtask : t_faults
  task automatic t_float();
    cmdFloat <= 1'b1;
    cyc(LAT + 3);
    chk(stageOn, 1'b0);
    cmdFloat <= 1'b0;
    turnOn();
    disFloat <= 1'b1;
    waitV(1, 1'b1, LAT + 3);
    discharge();
    disFloat <= 1'b0;
    turnOff();
  endtask : t_float
  initial begin
    cyc(4);
    reset_n <= 1'b1;
    cyc(LAT + 4);
    t_switch();
    t_thermal();
    t_disable();
    t_faults();
    t_float();
    final_report();
  end
  initial begin
    cyc(5000);
    errors++;
    final_report();
  end
endmodule : tb
